// ### pkg/cis_pkg.sv
package cis_pkg;
  localparam int          CIS_ADDR_W     = 8;
  localparam int          CIS_DATA_W     = 8;
  localparam int          CIS_CODE_W     = 4;
  localparam int          CIS_SRC_N      = 16;
  localparam logic [7:0]  CIS_SFR_PAGE   = 8'h00;
  localparam logic [7:0]  CIS_SFR_ADDR   = 8'h9E;
  localparam logic [7:0]  CIS_RESET      = 8'hFF;
  localparam logic [7:0]  CIS_RDATA_IDLE = 8'h00;
  localparam int          CIS_NEG_HI     = 7;
  localparam int          CIS_NEG_LO     = 4;
  localparam int          CIS_POS_HI     = 3;
  localparam int          CIS_POS_LO     = 0;
  localparam logic [3:0]  CIS_CODE_TOUCH = 4'hC;
  localparam logic [3:0]  CIS_CODE_HALF  = 4'hD;
  localparam logic [3:0]  CIS_CODE_NEG_RSVD = 4'hB;
  localparam logic [15:0] CIS_NO_MASK    = 16'h0000;
  localparam logic [15:0] CIS_NEG_MASK   = 16'h0800;
  localparam logic [15:0] CIS_SEL_NONE   = 16'h0000;
  localparam logic [15:0] CIS_SEL_ONE    = 16'h0001;

  function automatic logic [15:0] cis_onehot(input logic [3:0] code);
    cis_onehot = CIS_SEL_ONE << code;
  endfunction
endpackage

// ### tb/cis_input_select_bench.sv
`timescale 1ns/10ps
module cis_input_select_bench import cis_pkg::*;;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  sfr_page = 8'h00;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [3:0]  neg_code, pos_code;
  logic [15:0] neg_sel, pos_sel;
  logic        neg_touch, pos_touch, neg_half, pos_half;
  int          errors = 0;
  int          checks_done = 0;

  cis_input_select DUT (.clock(clock), .nrst(nrst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .negative_source_code(neg_code), .positive_source_code(pos_code),
    .negative_source_select(neg_sel), .positive_source_select(pos_sel),
    .negative_touch_ref(neg_touch), .positive_touch_ref(pos_touch),
    .negative_half_supply(neg_half), .positive_half_supply(pos_half));

  always #5 clock = ~clock;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle strobe; on return read data or new codes are visible
  task automatic acc(input logic [7:0] pg, input logic [7:0] ad, input logic w,
                     input logic [7:0] d);
    @(negedge clock);
    sfr_page = pg;
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge clock);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  endtask

  task automatic complete_run;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #50000;
    errors++;
    complete_run;
  end

  initial begin
    logic [3:0] n, p;
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    acc(CIS_SFR_PAGE, CIS_SFR_ADDR, 1'b0, 8'h00);
    chk(sfr_rdata, 16'h00FF);
    chk(neg_sel, 16'h8000);
    chk({neg_code, pos_code}, 16'h00FF);
    chk(pos_sel, 16'h8000);
    for (int c = 0; c < 16; c++) begin
      n = c[3:0];
      p = 4'hF - n;
      acc(CIS_SFR_PAGE, CIS_SFR_ADDR, 1'b1, {n, p});
      chk(neg_code, n);
      chk(pos_code, p);
      @(negedge clock);
      chk(neg_sel, (n == 4'hB) ? 16'h0000 : (16'h0001 << n));
      chk(pos_sel, 16'h0001 << p);
      chk({neg_touch, pos_touch}, {n == 4'hC, p == 4'hC});
      chk({neg_half, pos_half}, {n == 4'hD, p == 4'hD});
      acc(CIS_SFR_PAGE, CIS_SFR_ADDR, 1'b0, 8'h00);
      chk(sfr_rdata, {n, p});
      @(negedge clock);
      chk(sfr_rdata, 16'h0000);
    end
    // neighbouring page and address must be ignored
    acc(8'h01, CIS_SFR_ADDR, 1'b1, 8'h5A);
    acc(CIS_SFR_PAGE, 8'h9F, 1'b1, 8'hA5);
    acc(CIS_SFR_PAGE, 8'h9F, 1'b0, 8'h00);
    chk(sfr_rdata, 16'h0000);
    acc(CIS_SFR_PAGE, CIS_SFR_ADDR, 1'b0, 8'h00);
    chk(sfr_rdata, 16'h00F0);
    // second reset in mid-run
    @(negedge clock);
    nrst = 1'b0;
    @(negedge clock);
    chk({neg_code, pos_code}, 16'h00FF);
    nrst = 1'b1;
    @(negedge clock);
    chk(neg_sel, 16'h8000);
    chk(pos_sel, 16'h8000);
    chk({neg_touch, pos_touch, neg_half, pos_half}, 16'h0000);
    complete_run;
  end
endmodule // cis_input_select_bench

// ### verilog/cis_input_select.sv
`timescale 1ns/10ps
// Overview of operation
// RQ1 - bits 7:4 select negative input source
// RQ2 - bits 3:0 select positive input source
// RQ3 - register at page 0x0, address 0x9E
// RQ4 - code 1100 selects touch-sense reference
// RQ5 - code 1101 selects supply divided by two
// RQ6 - reset value all ones in both fields
module cis_input_select
  import cis_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic [CIS_ADDR_W-1:0] sfr_page,
  input  wire logic [CIS_ADDR_W-1:0] sfr_addr,
  input  wire logic                  sfr_wr,
  input  wire logic                  sfr_rd,
  input  wire logic [CIS_DATA_W-1:0] sfr_wdata,
  output logic      [CIS_DATA_W-1:0] sfr_rdata,
  output logic      [CIS_CODE_W-1:0] negative_source_code,
  output logic      [CIS_CODE_W-1:0] positive_source_code,
  output logic      [CIS_SRC_N-1:0]  negative_source_select,
  output logic      [CIS_SRC_N-1:0]  positive_source_select,
  output logic                       negative_touch_ref,
  output logic                       positive_touch_ref,
  output logic                       negative_half_supply,
  output logic                       positive_half_supply
);
  logic                  hit;
  logic [CIS_DATA_W-1:0] comparator1_input_select;

  assign hit = (sfr_page == CIS_SFR_PAGE) && (sfr_addr == CIS_SFR_ADDR); // [RQ3]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      comparator1_input_select <= CIS_RESET; // [RQ6]
    end else if (sfr_wr && hit) begin
      comparator1_input_select <= sfr_wdata; // [RQ3]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= CIS_RDATA_IDLE;
    end else if (sfr_rd && hit) begin
      sfr_rdata <= comparator1_input_select; // [RQ3]
    end else begin
      sfr_rdata <= CIS_RDATA_IDLE;
    end
  end

  assign negative_source_code = comparator1_input_select[CIS_NEG_HI:CIS_NEG_LO]; // [RQ1]
  assign positive_source_code = comparator1_input_select[CIS_POS_HI:CIS_POS_LO]; // [RQ2]

  cis_source_decoder #(
    .RESERVED_MASK (CIS_NEG_MASK)
  ) u_negative (
    .clock              (clock),
    .nrst               (nrst),
    .code               (negative_source_code),
    .source_select      (negative_source_select),
    .touch_ref_select   (negative_touch_ref),
    .half_supply_select (negative_half_supply)
  );

  // positive side reset code 1111 decodes from the same all-ones reset value
  cis_source_decoder #(
    .RESERVED_MASK (CIS_NO_MASK)
  ) u_positive (
    .clock              (clock),
    .nrst               (nrst),
    .code               (positive_source_code),
    .source_select      (positive_source_select),
    .touch_ref_select   (positive_touch_ref),
    .half_supply_select (positive_half_supply)
  );

  a_write_stores_byte: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
    (sfr_wr && hit) |=> comparator1_input_select == $past(sfr_wdata))
    else $error("addressed write not stored");

  a_other_addr_keeps: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
    (sfr_wr && !hit) |=> $stable(comparator1_input_select))
    else $error("unaddressed write changed register");

  a_read_returns_reg: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
    (sfr_rd && hit && !sfr_wr) |=> sfr_rdata == $past(comparator1_input_select))
    else $error("read data mismatch");

  a_neg_field_drives: assert property (@(posedge clock) disable iff (!nrst) // [RQ1]
    (sfr_wr && hit && sfr_wdata[CIS_NEG_HI:CIS_NEG_LO] == CIS_CODE_TOUCH)
      |=> ##1 negative_touch_ref)
    else $error("negative field did not steer touch reference");

  a_pos_field_drives: assert property (@(posedge clock) disable iff (!nrst) // [RQ2]
    (sfr_wr && hit && sfr_wdata[CIS_POS_HI:CIS_POS_LO] == CIS_CODE_HALF)
      |=> ##1 positive_half_supply && !positive_touch_ref)
    else $error("positive field did not steer half supply");

  a_reset_all_ones: assert property (@(posedge clock) // [RQ6]
    $rose(nrst) |-> comparator1_input_select == CIS_RESET
      && positive_source_select == cis_onehot(CIS_RESET[CIS_POS_HI:CIS_POS_LO]))
    else $error("register not all ones after reset");

  a_idle_rdata: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
    !(sfr_rd && hit)
      |=> sfr_rdata == CIS_RDATA_IDLE)
    else $error("read data not idle without addressed read");

  a_page_refused: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
    (sfr_wr && sfr_page != CIS_SFR_PAGE)
      |=> $stable(comparator1_input_select))
    else $error("write on other page changed register");

  a_addr_refused: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
    (sfr_wr && sfr_addr != CIS_SFR_ADDR)
      |=> $stable(comparator1_input_select))
    else $error("write to other address changed register");

  a_hold_no_write: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
    !(sfr_wr && hit)
      |=> $stable(comparator1_input_select))
    else $error("register changed without addressed write");

  a_wr_neg_code: assert property (@(posedge clock) disable iff (!nrst) // [RQ1]
    (sfr_wr && hit)
      |=> negative_source_code == $past(sfr_wdata[CIS_NEG_HI:CIS_NEG_LO]))
    else $error("negative code not taken from upper nibble");

  a_wr_pos_code: assert property (@(posedge clock) disable iff (!nrst) // [RQ2]
    (sfr_wr && hit)
      |=> positive_source_code == $past(sfr_wdata[CIS_POS_HI:CIS_POS_LO]))
    else $error("positive code not taken from lower nibble");

  a_neg_select_map: assert property (@(posedge clock) disable iff (!nrst) // [RQ1]
    (negative_source_code != CIS_CODE_NEG_RSVD)
      |=> negative_source_select == cis_onehot($past(negative_source_code)))
    else $error("negative select does not follow code");

  a_neg_reserved_open: assert property (@(posedge clock) disable iff (!nrst) // [RQ1]
    (negative_source_code == CIS_CODE_NEG_RSVD)
      |=> negative_source_select == CIS_SEL_NONE)
    else $error("reserved negative code connected a source");

  a_pos_select_map: assert property (@(posedge clock) disable iff (!nrst) // [RQ2]
    1'b1
      |=> positive_source_select == cis_onehot($past(positive_source_code)))
    else $error("positive select does not follow code");

  a_neg_touch_on: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
    (negative_source_code == CIS_CODE_TOUCH)
      |=> negative_touch_ref)
    else $error("negative touch reference not selected");

  a_neg_touch_off: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
    (negative_source_code != CIS_CODE_TOUCH)
      |=> !negative_touch_ref)
    else $error("negative touch reference selected without code");

  a_pos_touch_on: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
    (positive_source_code == CIS_CODE_TOUCH)
      |=> positive_touch_ref)
    else $error("positive touch reference not selected");

  a_pos_touch_off: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
    (positive_source_code != CIS_CODE_TOUCH)
      |=> !positive_touch_ref)
    else $error("positive touch reference selected without code");

  a_neg_half_on: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
    (negative_source_code == CIS_CODE_HALF)
      |=> negative_half_supply)
    else $error("negative half supply not selected");

  a_neg_half_off: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
    (negative_source_code != CIS_CODE_HALF)
      |=> !negative_half_supply)
    else $error("negative half supply selected without code");

  a_pos_half_on: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
    (positive_source_code == CIS_CODE_HALF)
      |=> positive_half_supply)
    else $error("positive half supply not selected");

  a_pos_half_off: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
    (positive_source_code != CIS_CODE_HALF)
      |=> !positive_half_supply)
    else $error("positive half supply selected without code");

  a_pos_field_touch: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
    (sfr_wr && hit && sfr_wdata[CIS_POS_HI:CIS_POS_LO] == CIS_CODE_TOUCH)
      |=> ##1 positive_touch_ref && !positive_half_supply)
    else $error("positive field did not steer touch reference");

  a_neg_field_half: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
    (sfr_wr && hit && sfr_wdata[CIS_NEG_HI:CIS_NEG_LO] == CIS_CODE_HALF)
      |=> ##1 negative_half_supply && !negative_touch_ref)
    else $error("negative field did not steer half supply");

  a_touch_matches_sel: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
    negative_touch_ref == negative_source_select[CIS_CODE_TOUCH]
      && positive_touch_ref == positive_source_select[CIS_CODE_TOUCH])
    else $error("touch flag disagrees with select");

  a_half_matches_sel: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
    negative_half_supply == negative_source_select[CIS_CODE_HALF]
      && positive_half_supply == positive_source_select[CIS_CODE_HALF])
    else $error("half supply flag disagrees with select");

  a_reset_neg_side: assert property (@(posedge clock) // [RQ6]
    $rose(nrst) |-> negative_source_select == cis_onehot(CIS_RESET[CIS_NEG_HI:CIS_NEG_LO])
      && !negative_touch_ref && !negative_half_supply)
    else $error("negative side not at ground after reset");

  a_reset_codes: assert property (@(posedge clock) // [RQ6]
    $rose(nrst) |-> negative_source_code == CIS_RESET[CIS_NEG_HI:CIS_NEG_LO]
      && positive_source_code == CIS_RESET[CIS_POS_HI:CIS_POS_LO])
    else $error("codes not all ones after reset");

  a_reset_pos_flags: assert property (@(posedge clock) // [RQ6]
    $rose(nrst) |-> !positive_touch_ref && !positive_half_supply
      && sfr_rdata == CIS_RDATA_IDLE)
    else $error("positive flags or read data not idle after reset");

  a_reset_code_sel: assert property (@(posedge clock) // [RQ6]
    $rose(nrst) |-> positive_source_select == negative_source_select
      && positive_source_select == cis_onehot(CIS_RESET[CIS_POS_HI:CIS_POS_LO]))
    else $error("selects differ after reset");
endmodule // cis_input_select

// ### verilog/cis_source_decoder.sv
`timescale 1ns/10ps
module cis_source_decoder
  import cis_pkg::*;
#(
  parameter logic [15:0] RESERVED_MASK = CIS_NO_MASK
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic [CIS_CODE_W-1:0] code,
  output logic      [CIS_SRC_N-1:0]  source_select,
  output logic                       touch_ref_select,
  output logic                       half_supply_select
);
  // both fields reset to the same all-ones code
  localparam logic [CIS_SRC_N-1:0] RESET_SELECT =
    CIS_SEL_ONE << CIS_RESET[CIS_NEG_HI:CIS_NEG_LO];

  logic [CIS_SRC_N-1:0] next_select;

  // reserved codes leave the input unconnected
  always_comb begin
    next_select = cis_onehot(code) & ~RESERVED_MASK;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      source_select <= RESET_SELECT;
    end else begin
      source_select <= next_select;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      touch_ref_select   <= 1'b0;
      half_supply_select <= 1'b0;
    end else begin
      touch_ref_select   <= (code == CIS_CODE_TOUCH); // [RQ4]
      half_supply_select <= (code == CIS_CODE_HALF);  // [RQ5]
    end
  end

  a_touch_follows_code: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
    (code == CIS_CODE_TOUCH) |=> touch_ref_select && source_select[CIS_CODE_TOUCH])
    else $error("touch reference not selected one cycle after code");

  a_half_follows_code: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
    (code == CIS_CODE_HALF) |=> half_supply_select && !touch_ref_select)
    else $error("half supply not selected one cycle after code");

  a_select_onehot: assert property (@(posedge clock) disable iff (!nrst)
    $onehot0(source_select))
    else $error("more than one source selected");
endmodule // cis_source_decoder
